// ---- sim/xrd_core_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module xrd_core_model (
    // clock
    input  wire logic        clk,
    // move request
    output var  logic        req,
    output var  logic        we,
    output var  logic        ptr16,
    output var  logic [15:0] data_pointer,
    output var  logic [7:0]  idx,
    output var  logic [7:0]  wdata,
    // answer
    input  wire logic [7:0]  rdata,
    input  wire logic        ack
);
    initial begin
        req = 1'b0;
        we = 1'b0;
        ptr16 = 1'b0;
        data_pointer = 16'h0000;
        idx = 8'h00;
        wdata = 8'h00;
    end

    task automatic issue(input logic w, input logic p,
                         input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        ptr16 <= p;
        data_pointer <= a;
        idx <= a[7:0];
        wdata <= d;
        @(posedge clk);
        req <= 1'b0;
        // address and data fields mean nothing once req is gone; never leave them stale
        data_pointer <= ~a;
        idx <= ~a[7:0];
        wdata <= ~d;
    endtask : issue

    task automatic move(input logic w, input logic p, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] rd,
                        output bit ok);
        ok = 1'b0;
        issue(w, p, a, d);
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge clk);
            ok = (ack === 1'b1);
        end
        rd = rdata;
    endtask : move
endmodule : xrd_core_model

`default_nettype wire

// ---- sim/xrd_top_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

module xrd_top_assertions (
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    // register bus
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        ACK_O,
    // core moves
    input wire logic        XM_REQ,
    input wire logic        XM_ACK,
    input wire logic [7:0]  XM_RDATA,
    // code space
    input wire logic [15:0] FETCH_ADDR,
    input wire logic        CB_FROM_EXT,
    input wire logic        FETCH_INTERNAL,
    input wire logic        CB_BLOCKED,
    // pins
    input wire logic        EXT_DATA_OE,
    input wire logic        EXT_RD_N,
    input wire logic        EXT_WR_N
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    AST_BUS_ACK: assert property (
        CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("bus ack late");
    AST_BUS_PULSE: assert property (
        ACK_O |=> !ACK_O) else $error("bus ack too long");
    AST_FETCH_HIGH: assert property (
        FETCH_ADDR >= 16'h8000 |=> !FETCH_INTERNAL)
        else $error("high fetch internal");
    AST_CB_OWN: assert property (
        !CB_FROM_EXT |=> !CB_BLOCKED) else $error("internal read blocked");
    AST_XM_PULSE: assert property (
        XM_ACK |=> !XM_ACK) else $error("move ack too long");
    AST_XM_LAT: assert property (
        XM_REQ |-> (##3 XM_ACK) or (##6 XM_ACK))
        else $error("move latency wrong");
    AST_WR_DRIVE: assert property (
        !EXT_WR_N |-> EXT_DATA_OE) else $error("write strobe undriven");
    AST_RD_END: assert property (
        $rose(EXT_RD_N) |-> XM_ACK) else $error("read strobe end");
    AST_RDATA_HOLD: assert property (
        !XM_ACK |-> $stable(XM_RDATA)) else $error("read data moved");

    cover property (XM_REQ ##3 XM_ACK);
    cover property (XM_REQ ##6 XM_ACK);
    cover property (!EXT_WR_N);
    cover property (CB_BLOCKED);
endmodule : xrd_top_assertions

`default_nettype wire

// ---- sim/xrd_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "xrd_cfg.svh"

module xrd_top_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        wen = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [15:0] fa = 16'h0000;
    logic [15:0] ca = 16'h0000;
    logic        cfe = 1'b0;
    logic        ea = 1'b1;
    logic        wr_seen = 1'b0;
    logic [7:0]  wd_seen = 8'h00;
    int          miscompares = 0;
    int          tests_run = 0;
    wire logic [31:0] dat_o;
    wire logic ack, xm_req, xm_we, xm_p16, xm_ack, fi, cbi, cbb, oe, rd_n, wr_n;
    wire logic [15:0] xm_dp, ext_a;
    wire logic [7:0]  xm_ix, xm_wd, xm_rd, ext_do, ext_di;

    // external memory: data is a function of the full address
    function automatic logic [7:0] ext(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5A;
    endfunction : ext
    assign ext_di = rd_n ? ~ext_a[7:0] : ext(ext_a);

    always #5 clk = ~clk;
    always @(posedge clk) if (wr_n === 1'b0) wr_seen <= 1'b1;
    // far-side memory latches the bus data under its write strobe
    always @(posedge clk) if (wr_n === 1'b0) wd_seen <= ext_do;

    xrd_top #(.CODE_PROTECT(1'b1)) xrd_top_inst (
        .REF_CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(wen),
        .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
        .XM_REQ(xm_req), .XM_WE(xm_we), .XM_PTR16(xm_p16),
        .XM_DATA_POINTER(xm_dp), .XM_INDEX_REGISTER(xm_ix),
        .XM_WDATA(xm_wd), .XM_RDATA(xm_rd), .XM_ACK(xm_ack),
        .FETCH_ADDR(fa), .CB_ADDR(ca), .CB_FROM_EXT(cfe),
        .FETCH_INTERNAL(fi), .CB_INTERNAL(cbi), .CB_BLOCKED(cbb),
        .EXTERNAL_ACCESS_SELECT(ea), .EXT_DATA_IN(ext_di), .EXT_ADDR(ext_a),
        .EXT_DATA_OUT(ext_do), .EXT_DATA_OE(oe), .EXT_RD_N(rd_n),
        .EXT_WR_N(wr_n));

    xrd_core_model xrd_core_model_inst (
        .clk(clk), .req(xm_req), .we(xm_we), .ptr16(xm_p16), .data_pointer(xm_dp),
        .idx(xm_ix), .wdata(xm_wd), .rdata(xm_rd), .ack(xm_ack));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic tmo;
        miscompares++;
        wrap_up();
    endtask : tmo

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset

    task automatic wb(input logic w, input logic [7:0] ix,
                      input logic [7:0] d, output logic [31:0] rd);
        bit ok;
        ok = 1'b0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= w;
        adr <= {2'b00, ix, 2'b00};
        dat_i <= {24'h000000, d};
        for (int i = 0; i < 10 && !ok; i++) begin
            @(posedge clk);
            ok = (ack === 1'b1);
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (!ok) tmo();
    endtask : wb

    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic [31:0] rd;
        wb(1'b1, ix, d, rd);
    endtask : wr

    task automatic rdchk(input logic [7:0] ix, input logic [7:0] exp);
        logic [31:0] rd;
        wb(1'b0, ix, 8'h00, rd);
        chk(rd, {24'h000000, exp});
    endtask : rdchk

    task automatic mv(input logic w, input logic p, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] rd);
        bit ok;
        xrd_core_model_inst.move(w, p, a, d, rd, ok);
        if (!ok) tmo();
    endtask : mv

    task automatic mvr(input logic p, input logic [15:0] a,
                       input logic [7:0] exp);
        logic [7:0] rd;
        mv(1'b0, p, a, 8'h00, rd);
        chk({24'h000000, rd}, {24'h000000, exp});
    endtask : mvr

    task automatic mvw(input logic p, input logic [15:0] a,
                       input logic [7:0] d);
        logic [7:0] rd;
        mv(1'b1, p, a, d, rd);
    endtask : mvw

    task automatic tc(input logic e, input logic [15:0] f,
                      input logic [15:0] c, input logic x,
                      input logic [2:0] exp);
        @(posedge clk);
        ea <= e;
        fa <= f;
        ca <= c;
        cfe <= x;
        // pin synchroniser plus output register
        repeat (6) @(posedge clk);
        chk({29'h0, fi, cbi, cbb}, {29'h0, exp});
    endtask : tc

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        rdchk(`XRD_IDX_PAGE, 8'h00);
        rdchk(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h01);
        rdchk(`XRD_IDX_PORT2, 8'hFF);
        rdchk(8'h55, 8'h00);
    endtask : t_reset_vals

    task automatic t_code;
        tc(1'b1, 16'h0100, 16'h0200, 1'b1, 3'b101);
        tc(1'b1, 16'h7FFF, 16'h0200, 1'b0, 3'b110);
        tc(1'b1, 16'h8000, 16'h9000, 1'b0, 3'b000);
        tc(1'b0, 16'h0100, 16'h0200, 1'b0, 3'b000);
        tc(1'b1, 16'h0100, 16'h0200, 1'b0, 3'b110);
    endtask : t_code

    task automatic t_disabled;
        wr_seen <= 1'b0;
        mvr(1'b1, 16'hF800, ext(16'hF800));
        mvw(1'b1, 16'hF810, 8'h33);
        chk({31'h0, wr_seen}, 32'h1);
        chk({24'h0, wd_seen}, 32'h33);
    endtask : t_disabled

    task automatic t_enable;
        wr(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h00);
        rdchk(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h00);
        wr(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h01);
        rdchk(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h00);
    endtask : t_enable

    task automatic t_ptr;
        wr_seen <= 1'b0;
        mvw(1'b1, 16'hF805, 8'hA5);
        mvw(1'b1, 16'hFBFF, 8'h5C);
        mvr(1'b1, 16'hF805, 8'hA5);
        mvr(1'b1, 16'hFBFF, 8'h5C);
        mvr(1'b1, 16'hFC05, 8'hA5);
        mvr(1'b1, 16'hF7F0, ext(16'hF7F0));
        rdchk(`XRD_IDX_STATUS, 8'h00);
        chk({31'h0, wr_seen}, 32'h0);
        wr(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h02);
        mvw(1'b1, 16'hF806, 8'h6B);
        chk({31'h0, wr_seen}, 32'h1);
        mvr(1'b1, 16'hF806, 8'h6B);
        rdchk(`XRD_IDX_STATUS, 8'h02);
    endtask : t_ptr

    task automatic t_page;
        wr(`XRD_IDX_PAGE, 8'hF9);
        rdchk(`XRD_IDX_PAGE, 8'hF9);
        mvw(1'b0, 16'h0005, 8'h3C);
        mvr(1'b1, 16'hF905, 8'h3C);
        wr(`XRD_IDX_PORT2, 8'h12);
        rdchk(`XRD_IDX_PAGE, 8'h12);
        mvr(1'b0, 16'h0034, ext(16'h1234));
        wr(`XRD_IDX_PAGE, 8'hF7);
        mvr(1'b0, 16'h0034, ext(16'h1234));
    endtask : t_page

    task automatic t_reset_write;
        mvw(1'b1, 16'hF820, 8'h11);
        xrd_core_model_inst.issue(1'b1, 1'b1, 16'hF820, 8'h77);
        do_reset();
        wr(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h00);
        mvr(1'b1, 16'hF820, 8'h11);
        xrd_core_model_inst.issue(1'b1, 1'b1, 16'hF820, 8'h99);
        @(posedge clk);
        do_reset();
        rdchk(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h01);
        wr(`XRD_IDX_SYSTEM_CONTROL_REGISTER, 8'h00);
        mvr(1'b1, 16'hF820, 8'h99);
    endtask : t_reset_write

    initial begin
        do_reset();
        t_reset_vals();
        t_code();
        t_disabled();
        t_enable();
        t_ptr();
        t_page();
        t_reset_write();
        wrap_up();
    end
endmodule : xrd_top_tb_top

bind xrd_top xrd_top_assertions xrd_top_assertions_inst (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I),
    .ACK_O(ACK_O), .XM_REQ(XM_REQ), .XM_ACK(XM_ACK), .XM_RDATA(XM_RDATA),
    .FETCH_ADDR(FETCH_ADDR), .CB_FROM_EXT(CB_FROM_EXT),
    .FETCH_INTERNAL(FETCH_INTERNAL), .CB_BLOCKED(CB_BLOCKED),
    .EXT_DATA_OE(EXT_DATA_OE), .EXT_RD_N(EXT_RD_N), .EXT_WR_N(EXT_WR_N));

`default_nettype wire

// ---- src/xrd_cfg.svh ----
`ifndef XRD_CFG_SVH
`define XRD_CFG_SVH

// register indices; byte address on the bus is four times the index
`define XRD_IDX_PAGE      8'h91
`define XRD_IDX_SYSTEM_CONTROL_REGISTER    8'hB1
`define XRD_IDX_PORT2     8'h20
`define XRD_IDX_STATUS    8'h21

// system control register fields
`define XRD_BIT_DISABLE   0
`define XRD_BIT_STROBE    1
`define XRD_RST_DISABLE   1'h1
`define XRD_RST_STROBE    1'h0

// status register fields
`define XRD_BIT_BUSY      0
`define XRD_BIT_LAST_INT  1

// reset values
`define XRD_RST_PAGE      8'h00
`define XRD_RST_PORT2     8'hFF

// address map
`define XRD_EXTENDED_RAM_PAGE     8'hF8
`define XRD_CODE_LIMIT    16'h8000

// wait count that ends the second move cycle on the external bus (four clocks); covers the
// three-stage synchroniser on the read data pins
`define XRD_EXT_WAIT      2'h3

`endif

// ---- src/xrd_pkg.sv ----
package xrd_pkg;

    typedef enum logic [1:0] {
        XM_IDLE,
        XM_CYC1,
        XM_CYC2
    } xrd_state_e;

    typedef logic [7:0]  xrd_byte_t;
    typedef logic [15:0] xrd_addr_t;
    typedef logic [9:0]  xrd_index_t;

endpackage : xrd_pkg

// ---- src/xrd_ram.sv ----
`timescale 1ns/10ps
`default_nettype none

// contents survive reset: the array and its read register have no reset
module xrd_ram
    import xrd_pkg::*;
(
    // clock
    input  wire logic       clk,
    // access
    input  wire logic       wr_en,
    input  wire xrd_index_t addr,
    input  wire xrd_byte_t  wr_data,
    output var  xrd_byte_t  rd_data
);

    xrd_byte_t mem [0:1023];
    xrd_byte_t rd_q;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_q <= mem[addr];
    end

    assign rd_data = rd_q;

endmodule : xrd_ram

`default_nettype wire

// ---- src/xrd_top.sv ----
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "xrd_cfg.svh"

module xrd_top
    import xrd_pkg::*;
#(
    parameter bit CODE_PROTECT = 1'b0
)
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [11:0] ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output var  logic [31:0] DAT_O,
    output var  logic        ACK_O,
    // core external data moves
    input  wire logic        XM_REQ,
    input  wire logic        XM_WE,
    input  wire logic        XM_PTR16,
    input  wire logic [15:0] XM_DATA_POINTER,
    input  wire logic [7:0]  XM_INDEX_REGISTER,
    input  wire logic [7:0]  XM_WDATA,
    output var  logic [7:0]  XM_RDATA,
    output var  logic        XM_ACK,
    // core program fetch and code byte moves
    input  wire logic [15:0] FETCH_ADDR,
    input  wire logic [15:0] CB_ADDR,
    input  wire logic        CB_FROM_EXT,
    output var  logic        FETCH_INTERNAL,
    output var  logic        CB_INTERNAL,
    output var  logic        CB_BLOCKED,
    // pins
    input  wire logic        EXTERNAL_ACCESS_SELECT,
    input  wire logic [7:0]  EXT_DATA_IN,
    output var  logic [15:0] EXT_ADDR,
    output var  logic [7:0]  EXT_DATA_OUT,
    output var  logic        EXT_DATA_OE,
    output var  logic        EXT_RD_N,
    output var  logic        EXT_WR_N
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic in_extended_ram_page(input xrd_byte_t hi);
        in_extended_ram_page = (hi >= `XRD_EXTENDED_RAM_PAGE);
    endfunction : in_extended_ram_page

    function automatic logic reg_hit(input logic [11:0] adr,
                                     input xrd_byte_t   idx);
        reg_hit = (adr == {2'h0, idx, 2'h0});
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic       ea_s1_q, ea_s2_q, ea_s3_q, ea_q, ea_d;
    xrd_byte_t  din_s1_q, din_s2_q, din_s3_q;

    always_comb begin
        ea_d = ea_q;
        if (ea_s2_q == ea_s3_q) begin
            ea_d = ea_s3_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ea_s1_q  <= 1'h0;
            ea_s2_q  <= 1'h0;
            ea_s3_q  <= 1'h0;
            ea_q     <= 1'h0;
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
            din_s3_q <= 8'h00;
        end else begin
            ea_s1_q  <= EXTERNAL_ACCESS_SELECT;
            ea_s2_q  <= ea_s1_q;
            ea_s3_q  <= ea_s2_q;
            ea_q     <= ea_d;
            din_s1_q <= EXT_DATA_IN;
            din_s2_q <= din_s1_q;
            din_s3_q <= din_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    xrd_byte_t page_q, page_d;
    xrd_byte_t port2_q, port2_d;
    logic      dis_q, dis_d;
    logic      stb_en_q, stb_en_d;
    logic      wb_ack_q, wb_ack_d;
    logic [31:0] wb_dat_q, wb_dat_d;
    logic      wb_go, wb_wr;
    logic      extended_ram_en;
    // status sources, owned by the move sequencer below
    logic      busy;
    logic      last_int_q, last_int_d;

    assign wb_go   = CYC_I && STB_I && !wb_ack_q;
    assign wb_wr   = wb_go && WE_I && SEL_I[0];
    assign extended_ram_en = !dis_q;

    always_comb begin
        page_d   = page_q;
        port2_d  = port2_q;
        dis_d    = dis_q;
        stb_en_d = stb_en_q;
        wb_ack_d = wb_go;
        wb_dat_d = 32'h0000_0000;
        if (wb_wr && reg_hit(ADR_I, `XRD_IDX_PAGE)) begin
            page_d = DAT_I[7:0];
        end
        if (wb_wr && reg_hit(ADR_I, `XRD_IDX_PORT2)) begin
            port2_d = DAT_I[7:0];
            page_d  = DAT_I[7:0];
        end
        if (wb_wr && reg_hit(ADR_I, `XRD_IDX_SYSTEM_CONTROL_REGISTER)) begin
            // capacitor-like latch: software can only clear it
            dis_d    = dis_q && DAT_I[`XRD_BIT_DISABLE];
            stb_en_d = DAT_I[`XRD_BIT_STROBE];
        end
        if (wb_go && !WE_I) begin
            if (reg_hit(ADR_I, `XRD_IDX_PAGE)) begin
                wb_dat_d[7:0] = page_q;
            end
            if (reg_hit(ADR_I, `XRD_IDX_PORT2)) begin
                wb_dat_d[7:0] = port2_q;
            end
            if (reg_hit(ADR_I, `XRD_IDX_SYSTEM_CONTROL_REGISTER)) begin
                wb_dat_d[`XRD_BIT_DISABLE] = dis_q;
                wb_dat_d[`XRD_BIT_STROBE]  = stb_en_q;
            end
            if (reg_hit(ADR_I, `XRD_IDX_STATUS)) begin
                wb_dat_d[`XRD_BIT_BUSY]     = busy;
                wb_dat_d[`XRD_BIT_LAST_INT] = last_int_q;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            page_q   <= `XRD_RST_PAGE;
            port2_q  <= `XRD_RST_PORT2;
            dis_q    <= `XRD_RST_DISABLE;
            stb_en_q <= `XRD_RST_STROBE;
            wb_ack_q <= 1'h0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            page_q   <= page_d;
            port2_q  <= port2_d;
            dis_q    <= dis_d;
            stb_en_q <= stb_en_d;
            wb_ack_q <= wb_ack_d;
            wb_dat_q <= wb_dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external data move sequencer

    xrd_state_e st_q, st_d;
    xrd_addr_t  adr_q, adr_d;
    xrd_byte_t  wd_q, wd_d;
    xrd_byte_t  rd_q, rd_d;
    logic       we_q, we_d;
    logic       int_q, int_d;
    logic       strobe_q, strobe_d;
    logic       ack_q, ack_d;
    logic [1:0] wait_q, wait_d;
    logic       rd_n_q, rd_n_d, wr_n_q, wr_n_d, oe_q, oe_d;
    logic       sel_new;
    xrd_addr_t  req_addr;
    xrd_byte_t  ram_rd;

    assign busy = (st_q != XM_IDLE);

    always_comb begin
        // page supplies the high byte for index moves to the array; port2 supplies it on the external bus
        req_addr = XM_PTR16 ? XM_DATA_POINTER
                            : {page_q, XM_INDEX_REGISTER};
        // the whole top 2K is claimed, FC00h up aliases the array
        sel_new  = extended_ram_en && in_extended_ram_page(req_addr[15:8]);
    end

    always_comb begin
        st_d       = st_q;
        adr_d      = adr_q;
        wd_d       = wd_q;
        rd_d       = rd_q;
        we_d       = we_q;
        int_d      = int_q;
        strobe_d   = strobe_q;
        last_int_d = last_int_q;
        ack_d      = 1'h0;
        wait_d     = wait_q;
        unique case (st_q)
            XM_IDLE: begin
                if (XM_REQ) begin
                    st_d     = XM_CYC1;
                    we_d     = XM_WE;
                    wd_d     = XM_WDATA;
                    int_d    = sel_new;
                    strobe_d = !sel_new || stb_en_q;
                    adr_d    = req_addr;
                    if (!XM_PTR16 && !sel_new) begin
                        adr_d = {port2_q, XM_INDEX_REGISTER};
                    end
                end
            end
            XM_CYC1: begin
                // array write lands on this edge, so a reset during
                // cycle one drops it and one during cycle two does not
                st_d   = XM_CYC2;
                wait_d = 2'h0;
            end
            XM_CYC2: begin
                wait_d = wait_q + 2'h1;
                if (int_q || wait_q == `XRD_EXT_WAIT) begin
                    st_d       = XM_IDLE;
                    ack_d      = 1'h1;
                    last_int_d = int_q;
                    rd_d       = int_q ? ram_rd : din_s3_q;
                end
            end
            default: begin
                st_d = XM_IDLE;
            end
        endcase
    end

    always_comb begin
        rd_n_d = 1'h1;
        wr_n_d = 1'h1;
        oe_d   = 1'h0;
        if (st_d != XM_IDLE && strobe_d) begin
            rd_n_d = we_d;
            wr_n_d = !we_d;
            oe_d   = we_d;
        end else if (st_d != XM_IDLE && we_d) begin
            // write data still shown on the bus for debug viewing
            oe_d = 1'h1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q       <= XM_IDLE;
            adr_q      <= 16'h0000;
            wd_q       <= 8'h00;
            rd_q       <= 8'h00;
            we_q       <= 1'h0;
            int_q      <= 1'h0;
            strobe_q   <= 1'h0;
            last_int_q <= 1'h0;
            ack_q      <= 1'h0;
            wait_q     <= 2'h0;
            rd_n_q     <= 1'h1;
            wr_n_q     <= 1'h1;
            oe_q       <= 1'h0;
        end else begin
            st_q       <= st_d;
            adr_q      <= adr_d;
            wd_q       <= wd_d;
            rd_q       <= rd_d;
            we_q       <= we_d;
            int_q      <= int_d;
            strobe_q   <= strobe_d;
            last_int_q <= last_int_d;
            ack_q      <= ack_d;
            wait_q     <= wait_d;
            rd_n_q     <= rd_n_d;
            wr_n_q     <= wr_n_d;
            oe_q       <= oe_d;
        end
    end

    // array has no reset so contents persist
    xrd_ram u_ram (
        .clk     (REF_CLK),
        .wr_en   (st_q == XM_CYC1 && int_q && we_q),
        .addr    (adr_q[9:0]),
        .wr_data (wd_q),
        .rd_data (ram_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // code space split and protection

    logic fetch_int_q, fetch_int_d;
    logic cb_int_q, cb_int_d;
    logic cb_blk_q, cb_blk_d;
    logic cb_low;

    always_comb begin
        cb_low      = (CB_ADDR < `XRD_CODE_LIMIT) && ea_q;
        fetch_int_d = ea_q && (FETCH_ADDR < `XRD_CODE_LIMIT);
        // only external-fetched reads of internal code are stopped
        cb_blk_d    = CODE_PROTECT && CB_FROM_EXT && cb_low;
        cb_int_d    = cb_low && !cb_blk_d;
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fetch_int_q <= 1'h0;
            cb_int_q    <= 1'h0;
            cb_blk_q    <= 1'h0;
        end else begin
            fetch_int_q <= fetch_int_d;
            cb_int_q    <= cb_int_d;
            cb_blk_q    <= cb_blk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign DAT_O          = wb_dat_q;
    assign ACK_O          = wb_ack_q;
    assign XM_RDATA       = rd_q;
    assign XM_ACK         = ack_q;
    assign FETCH_INTERNAL = fetch_int_q;
    assign CB_INTERNAL    = cb_int_q;
    assign CB_BLOCKED     = cb_blk_q;
    assign EXT_ADDR       = adr_q;
    assign EXT_DATA_OUT   = wd_q;
    assign EXT_DATA_OE    = oe_q;
    assign EXT_RD_N       = rd_n_q;
    assign EXT_WR_N       = wr_n_q;

endmodule : xrd_top

`default_nettype wire
